// ### hdl/booklet_motor_home_supervisor.sv
// supervisor for the alignment and push motors of the booklet maker
// Function
// - align toward home: fault after 500 pulses
// - align leaving home: fault after 50 pulses
// - push toward home: fault after 0.3 s
// - push leaving home: fault after 80 ms
// - edge sensor not cleared in 80 ms: fault
// - edge sensor not reached in 0.3 s: fault
// - too few encoder pulses in drive: fault
// - both alignment faults share one identifier of their own
// - all push faults share one identifier
module booklet_motor_home_supervisor
  import motor_sup_pkg::*;
#(
  parameter int unsigned PUSH_ARRIVE_CYCLES = PUSH_ARRIVE_CYC,
  parameter int unsigned PUSH_LEAVE_CYCLES = PUSH_LEAVE_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire motor_cmd_s align_cmd_i,
  input wire motor_cmd_s push_cmd_i,
  input wire logic push_to_edge_i,
  input wire logic [PULSE_CNT_W-1:0] push_min_pulses_i,
  input wire logic align_step_i,
  input wire logic align_home_sensor_i,
  input wire logic push_home_sensor_i,
  input wire logic push_edge_sensor_i,
  input wire logic push_encoder_sensor_i,
  input wire logic push_done_i,
  output logic align_motor_en_o,
  output logic align_motor_dir_o,
  output logic push_motor_en_o,
  output logic push_motor_dir_o,
  output motor_stat_s align_stat_o,
  output motor_stat_s push_stat_o,
  output logic [ERR_ID_W-1:0] err_id_o
);
  logic a_home;
  logic p_home;
  logic p_edge;
  logic p_enc;

  pin_sync u_sync_ah (.clk_i(clk_i), .srst_i(srst_i), .pin_i(align_home_sensor_i),
    .level_o(a_home));
  pin_sync u_sync_ph (.clk_i(clk_i), .srst_i(srst_i), .pin_i(push_home_sensor_i),
    .level_o(p_home));
  pin_sync u_sync_pe (.clk_i(clk_i), .srst_i(srst_i), .pin_i(push_edge_sensor_i),
    .level_o(p_edge));
  pin_sync u_sync_pc (.clk_i(clk_i), .srst_i(srst_i), .pin_i(push_encoder_sensor_i),
    .level_o(p_enc));

  // alignment motor: pulse-counted supervision
  run_state_e a_st_r, a_st_nxt;
  logic a_tow_r, a_tow_nxt;
  logic [PULSE_CNT_W-1:0] a_cnt_r, a_cnt_nxt;

  always_comb begin
    a_st_nxt = a_st_r;
    a_tow_nxt = a_tow_r;
    a_cnt_nxt = a_cnt_r;
    case (a_st_r)
      ST_IDLE: begin
        if (align_cmd_i.start) begin
          a_st_nxt = ST_RUN;
          a_tow_nxt = align_cmd_i.toward;
          a_cnt_nxt = '0;
        end
      end
      ST_RUN: begin
        if (a_tow_r && a_home) begin
          a_st_nxt = ST_IDLE;
        end else if (!a_tow_r && !a_home) begin
          a_st_nxt = ST_IDLE;
        end else if (align_step_i) begin
          a_cnt_nxt = a_cnt_r + 1'b1;
          if (a_tow_r && a_cnt_r + 1'b1 >= PULSE_CNT_W'(ALIGN_HOME_PULSES)) begin
            a_st_nxt = ST_FAULT;
          end
          if (!a_tow_r && a_cnt_r + 1'b1 >= PULSE_CNT_W'(ALIGN_LEAVE_PULSES)) begin
            a_st_nxt = ST_FAULT;
          end
        end
      end
      ST_FAULT: a_st_nxt = ST_FAULT;
      default: a_st_nxt = ST_IDLE;
    endcase
    if (srst_i) begin
      a_st_nxt = ST_IDLE;
      a_tow_nxt = 1'b0;
      a_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    a_st_r <= a_st_nxt;
    a_tow_r <= a_tow_nxt;
    a_cnt_r <= a_cnt_nxt;
  end

  // push motor: time-limited supervision plus encoder count
  run_state_e p_st_r, p_st_nxt;
  logic p_tow_r, p_tow_nxt;
  logic p_edge_r, p_edge_nxt;
  logic p_left_r, p_left_nxt;
  logic p_enc_d_r, p_enc_d_nxt;
  logic [31:0] p_tmr_r, p_tmr_nxt;
  logic [PULSE_CNT_W-1:0] p_pc_r, p_pc_nxt;
  logic p_target;
  logic p_start_level;
  logic enc_rise;

  assign enc_rise = p_enc && !p_enc_d_r;
  // sensor that the drive must reach, and the one it must leave
  assign p_target = p_edge_r ? p_edge : p_home;
  assign p_start_level = p_edge_r ? p_home : p_edge;

  always_comb begin
    p_st_nxt = p_st_r;
    p_tow_nxt = p_tow_r;
    p_edge_nxt = p_edge_r;
    p_left_nxt = p_left_r;
    p_tmr_nxt = p_tmr_r;
    p_pc_nxt = p_pc_r;
    p_enc_d_nxt = p_enc;
    case (p_st_r)
      ST_IDLE: begin
        if (push_cmd_i.start) begin
          p_st_nxt = ST_RUN;
          p_tow_nxt = push_cmd_i.toward;
          p_edge_nxt = push_to_edge_i;
          p_left_nxt = 1'b0;
          p_tmr_nxt = '0;
          p_pc_nxt = '0;
        end
      end
      ST_RUN: begin
        p_tmr_nxt = p_tmr_r + 1'b1;
        if (enc_rise && p_pc_r != '1) begin
          p_pc_nxt = p_pc_r + 1'b1;
        end
        if (!p_start_level) begin
          p_left_nxt = 1'b1;
        end
        if (!p_left_r && p_start_level && p_tmr_r + 1'b1 >= PUSH_LEAVE_CYCLES) begin
          p_st_nxt = ST_FAULT;
        end else if (p_tow_r && !p_target && p_tmr_r + 1'b1 >= PUSH_ARRIVE_CYCLES) begin
          p_st_nxt = ST_FAULT;
        end else if ((p_tow_r && p_target) || (!p_tow_r && push_done_i)) begin
          if (p_pc_r < push_min_pulses_i) begin
            p_st_nxt = ST_FAULT;
          end else begin
            p_st_nxt = ST_IDLE;
          end
        end
      end
      ST_FAULT: p_st_nxt = ST_FAULT;
      default: p_st_nxt = ST_IDLE;
    endcase
    if (srst_i) begin
      p_st_nxt = ST_IDLE;
      p_tow_nxt = 1'b0;
      p_edge_nxt = 1'b0;
      p_left_nxt = 1'b0;
      p_tmr_nxt = '0;
      p_pc_nxt = '0;
      p_enc_d_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    p_st_r <= p_st_nxt;
    p_tow_r <= p_tow_nxt;
    p_edge_r <= p_edge_nxt;
    p_left_r <= p_left_nxt;
    p_tmr_r <= p_tmr_nxt;
    p_pc_r <= p_pc_nxt;
    p_enc_d_r <= p_enc_d_nxt;
  end

  // motors only run in ST_RUN, so a fault stops them at once
  assign align_motor_en_o = (a_st_r == ST_RUN);
  assign align_motor_dir_o = a_tow_r;
  assign push_motor_en_o = (p_st_r == ST_RUN);
  assign push_motor_dir_o = p_tow_r;
  assign align_stat_o = '{run: a_st_r == ST_RUN, toward: a_tow_r, fault: a_st_r == ST_FAULT};
  assign push_stat_o = '{run: p_st_r == ST_RUN, toward: p_tow_r, fault: p_st_r == ST_FAULT};

  // alignment identifier wins when both motors have failed
  always_comb begin
    if (a_st_r == ST_FAULT) begin
      err_id_o = ERR_ID_ALIGN;
    end else if (p_st_r == ST_FAULT) begin
      err_id_o = ERR_ID_PUSH;
    end else begin
      err_id_o = ERR_ID_NONE;
    end
  end

  a_fault_sticky: assert property (@(posedge clk_i) disable iff (srst_i)
    a_st_r == ST_FAULT |=> a_st_r == ST_FAULT && !align_motor_en_o)
    else $error("align fault not held");
  a_align_home_lim: assert property (@(posedge clk_i) disable iff (srst_i)
    a_st_r == ST_RUN && a_tow_r && !a_home && align_step_i
    && a_cnt_r == PULSE_CNT_W'(ALIGN_HOME_PULSES - 1) |=> a_st_r == ST_FAULT)
    else $error("align home limit missed");
  a_align_leave_lim: assert property (@(posedge clk_i) disable iff (srst_i)
    a_st_r == ST_RUN && !a_tow_r && a_home && align_step_i
    && a_cnt_r == PULSE_CNT_W'(ALIGN_LEAVE_PULSES - 1) |=> a_st_r == ST_FAULT)
    else $error("align leave limit missed");
  a_align_no_early: assert property (@(posedge clk_i) disable iff (srst_i)
    a_st_r == ST_RUN && a_cnt_r < PULSE_CNT_W'(ALIGN_LEAVE_PULSES - 1) |=> a_st_r != ST_FAULT)
    else $error("align fault too early");
  a_push_arrive_lim: assert property (@(posedge clk_i) disable iff (srst_i)
    p_st_r == ST_RUN && p_tow_r && !p_target && p_tmr_r + 1 >= PUSH_ARRIVE_CYCLES
    |=> p_st_r == ST_FAULT)
    else $error("push arrival limit missed");
  a_push_leave_lim: assert property (@(posedge clk_i) disable iff (srst_i)
    p_st_r == ST_RUN && !p_left_r && p_start_level && p_tmr_r + 1 >= PUSH_LEAVE_CYCLES
    |=> p_st_r == ST_FAULT)
    else $error("push leave limit missed");
  a_push_pulse_short: assert property (@(posedge clk_i) disable iff (srst_i)
    p_st_r == ST_RUN && p_tow_r && p_target && p_pc_r < push_min_pulses_i
    && p_tmr_r + 1 < PUSH_ARRIVE_CYCLES && (p_left_r || !p_start_level) |=> p_st_r == ST_FAULT)
    else $error("pulse shortfall not flagged");
  a_err_ids: assert property (@(posedge clk_i) disable iff (srst_i)
    (a_st_r == ST_FAULT) == (err_id_o == ERR_ID_ALIGN))
    else $error("align identifier mismatch");
  a_push_err_id: assert property (@(posedge clk_i) disable iff (srst_i)
    p_st_r == ST_FAULT && a_st_r != ST_FAULT |-> err_id_o == ERR_ID_PUSH)
    else $error("push identifier mismatch");
  a_push_stop: assert property (@(posedge clk_i) disable iff (srst_i)
    p_st_r == ST_FAULT |-> !push_motor_en_o ##1 p_st_r == ST_FAULT)
    else $error("push motor not stopped");

  c_align_ok: cover property (@(posedge clk_i) a_st_r == ST_RUN ##1 a_st_r == ST_IDLE);
  c_align_fault: cover property (@(posedge clk_i) a_st_r == ST_RUN ##1 a_st_r == ST_FAULT);
  c_push_ok: cover property (@(posedge clk_i) p_st_r == ST_RUN ##1 p_st_r == ST_IDLE);
  c_push_fault: cover property (@(posedge clk_i) p_st_r == ST_RUN ##1 p_st_r == ST_FAULT);
endmodule // booklet_motor_home_supervisor

// ### hdl/motor_sup_pkg.sv
// package: constants and types for the booklet motor home supervisor
package motor_sup_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned ALIGN_HOME_PULSES = 500;
  localparam int unsigned ALIGN_LEAVE_PULSES = 50;
  localparam int unsigned PUSH_ARRIVE_MS = 300;
  localparam int unsigned PUSH_LEAVE_MS = 80;
  localparam int unsigned PUSH_ARRIVE_CYC = PUSH_ARRIVE_MS * (CLK_HZ / 1000);
  localparam int unsigned PUSH_LEAVE_CYC = PUSH_LEAVE_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_CNT_W = 16;
  localparam int unsigned ERR_ID_W = 8;
  localparam logic [7:0] ERR_ID_NONE = 8'h00;
  localparam logic [7:0] ERR_ID_ALIGN = 8'h44;
  localparam logic [7:0] ERR_ID_PUSH = 8'h45;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_FAULT = 2'b10
  } run_state_e;

  typedef struct packed {
    logic start;
    logic toward;
  } motor_cmd_s;

  typedef struct packed {
    logic run;
    logic toward;
    logic fault;
  } motor_stat_s;
endpackage

// ### hdl/pin_sync.sv
// three-stage input synchroniser with agreement filter
module pin_sync (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic lvl_r;
  logic lvl_nxt;

  always_comb begin
    sh_nxt = srst_i ? 3'h0 : {sh_r[1:0], pin_i};
    lvl_nxt = srst_i ? 1'b0 : ((sh_r[2] == sh_r[1]) ? sh_r[2] : lvl_r);
  end

  always_ff @(posedge clk_i) begin
    sh_r <= sh_nxt;
    lvl_r <= lvl_nxt;
  end

  assign level_o = lvl_r;
endmodule // pin_sync

// ### verification/finisher_mech_model.sv
// behavioural plant: motor drivers, position sensors and encoder of the booklet maker
module finisher_mech_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic align_en_i,
  input wire logic align_dir_i,
  input wire logic push_en_i,
  input wire logic push_dir_i,
  input wire logic push_to_edge_i,
  input wire logic jam_i,
  input wire logic slow_i,
  output logic align_step_o,
  output logic align_home_sensor_o,
  output logic push_home_sensor_o,
  output logic push_edge_sensor_o,
  output logic push_encoder_sensor_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int apos;
  int ppos;
  logic [1:0] div;
  logic move;
  // crawl mode: departures still beat their limit, arrivals miss theirs
  assign move = push_en_i && !jam_i && (!slow_i || div == 2'd3);
  assign align_home_sensor_o = apos < 3;
  assign push_home_sensor_o = ppos < 8;
  assign push_edge_sensor_o = ppos >= 100;
  // encoder level holds for two moves, so the two-flop agreement filter still sees it
  assign push_encoder_sensor_o = ppos[1];
  always @(posedge clk_i) begin
    div <= srst_i ? 2'd0 : div + 2'd1;
    align_step_o <= !srst_i && align_en_i && div == 2'd3;
    // plates start clear of home, pusher at home
    if (srst_i) begin
      apos <= 10;
      ppos <= 0;
    end else begin
      // a jammed drive still steps, but nothing moves and no encoder edges come
      if (align_step_o && !jam_i) begin
        apos <= align_dir_i ? apos - 1 : apos + 1;
      end
      if (move) begin
        ppos <= (push_dir_i == push_to_edge_i) ? ppos + 1 : ppos - 1;
      end
    end
  end
endmodule // finisher_mech_model

// ### verification/booklet_motor_home_supervisor_tb.sv
// self-checking bench for the booklet motor home supervisor
module booklet_motor_home_supervisor_tb
  import motor_sup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic edge_sel = 1'b0;
  logic jam = 1'b0;
  logic slow = 1'b0;
  logic done = 1'b0;
  logic [15:0] min_pulses = 16'h000a;
  motor_cmd_s align_cmd = '0;
  motor_cmd_s push_cmd = '0;
  logic step, a_home, p_home, p_edge, p_enc, a_en, a_dir, p_en, p_dir;
  motor_stat_s a_stat, p_stat;
  logic [ERR_ID_W-1:0] err_id;
  int failures = 0;
  int samples_checked = 0;
  int n;

  always #4 clk_i = ~clk_i;

  booklet_motor_home_supervisor #(.PUSH_ARRIVE_CYCLES(300), .PUSH_LEAVE_CYCLES(80))
    booklet_motor_home_supervisor_inst (.clk_i(clk_i), .srst_i(srst_i),
    .align_cmd_i(align_cmd), .push_cmd_i(push_cmd), .push_to_edge_i(edge_sel),
    .push_min_pulses_i(min_pulses), .align_step_i(step), .align_home_sensor_i(a_home),
    .push_home_sensor_i(p_home), .push_edge_sensor_i(p_edge), .push_encoder_sensor_i(p_enc),
    .push_done_i(done), .align_motor_en_o(a_en), .align_motor_dir_o(a_dir),
    .push_motor_en_o(p_en), .push_motor_dir_o(p_dir), .align_stat_o(a_stat),
    .push_stat_o(p_stat), .err_id_o(err_id));

  finisher_mech_model finisher_mech_model_inst (.clk_i(clk_i), .srst_i(srst_i),
    .align_en_i(a_en), .align_dir_i(a_dir), .push_en_i(p_en), .push_dir_i(p_dir),
    .push_to_edge_i(edge_sel), .jam_i(jam), .slow_i(slow), .align_step_o(step),
    .align_home_sensor_o(a_home), .push_home_sensor_o(p_home),
    .push_edge_sensor_o(p_edge), .push_encoder_sensor_o(p_enc));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [15:0] win(input int v, input int lo, input int hi);
    return 16'(v >= lo && v <= hi);
  endfunction

  task automatic do_reset();
    srst_i = 1'b1;
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    // let the sensor synchronisers fill before the first command
    repeat (8) @(negedge clk_i);
  endtask

  // one start pulse, then count cycles while the motor enable stays up
  task automatic run(input logic is_push, input logic toward, output int len);
    if (is_push) push_cmd = '{start: 1'b1, toward: toward};
    else align_cmd = '{start: 1'b1, toward: toward};
    @(negedge clk_i);
    push_cmd = '0;
    align_cmd = '0;
    check("run_stat", is_push ? 16'({p_stat.run, p_stat.toward, p_dir})
      : 16'({a_stat.run, a_stat.toward, a_dir}), 16'({1'b1, toward, toward}));
    len = 0;
    while ((is_push ? p_en : a_en) !== 1'b0 && len < 4000) begin
      @(negedge clk_i);
      len++;
    end
  endtask

  // a fault must hold the motors off and ignore new starts
  task automatic latched(input logic [7:0] exp);
    // only the faulted motor is restarted; the idle one would legally run
    if (exp == ERR_ID_PUSH) push_cmd = '{start: 1'b1, toward: 1'b1};
    else align_cmd = '{start: 1'b1, toward: 1'b1};
    @(negedge clk_i);
    push_cmd = '0;
    align_cmd = '0;
    repeat (3) @(negedge clk_i);
    check("motor_en", 16'({a_en, p_en}), 16'h0000);
    check("fault_bits", 16'({a_stat.fault, p_stat.fault}),
      16'({exp == ERR_ID_ALIGN, exp == ERR_ID_PUSH}));
    check("err_id", 16'(err_id), 16'(exp));
  endtask

  task automatic push_travel();
    do_reset();
    edge_sel = 1'b1;
    run(1'b1, 1'b1, n);
    check("edge_arrive", win(n, 95, 125), 16'h0001);
    edge_sel = 1'b0;
    run(1'b1, 1'b1, n);
    check("home_arrive", win(n, 90, 130), 16'h0001);
    check("err_id", 16'(err_id), 16'h0000);
    edge_sel = 1'b1;
    min_pulses = 16'h03e8;
    run(1'b1, 1'b1, n);
    check("short_count", win(n, 95, 125), 16'h0001);
    latched(ERR_ID_PUSH);
    min_pulses = 16'h000a;
  endtask

  // away drive from home, ended by the done pulse; count judged at the end
  task automatic push_away(input logic [15:0] minp, input logic [7:0] exp);
    do_reset();
    edge_sel = 1'b0;
    min_pulses = minp;
    push_cmd = '{start: 1'b1, toward: 1'b0};
    @(negedge clk_i);
    push_cmd = '0;
    repeat (60) @(negedge clk_i);
    check("away_run", 16'(p_en), 16'h0001);
    done = 1'b1;
    @(negedge clk_i);
    done = 1'b0;
    @(negedge clk_i);
    check("away_end", 16'({p_en, p_stat.fault}), 16'({1'b0, exp == ERR_ID_PUSH}));
    check("err_id", 16'(err_id), 16'(exp));
    min_pulses = 16'h000a;
  endtask

  task automatic push_leave_faults();
    do_reset();
    jam = 1'b1;
    edge_sel = 1'b1;
    run(1'b1, 1'b1, n);
    check("home_leave", win(n, 75, 90), 16'h0001);
    latched(ERR_ID_PUSH);
    do_reset();
    jam = 1'b0;
    run(1'b1, 1'b1, n);
    jam = 1'b1;
    edge_sel = 1'b0;
    run(1'b1, 1'b1, n);
    check("edge_leave", win(n, 75, 90), 16'h0001);
    latched(ERR_ID_PUSH);
    jam = 1'b0;
  endtask

  task automatic push_arrive_faults();
    do_reset();
    slow = 1'b1;
    edge_sel = 1'b1;
    run(1'b1, 1'b1, n);
    check("edge_late", win(n, 295, 310), 16'h0001);
    latched(ERR_ID_PUSH);
    do_reset();
    slow = 1'b0;
    run(1'b1, 1'b1, n);
    slow = 1'b1;
    edge_sel = 1'b0;
    run(1'b1, 1'b1, n);
    check("home_late", win(n, 295, 310), 16'h0001);
    latched(ERR_ID_PUSH);
    slow = 1'b0;
  endtask

  task automatic align_faults();
    do_reset();
    jam = 1'b1;
    run(1'b0, 1'b1, n);
    check("align_home", win(n, 1990, 2012), 16'h0001);
    latched(ERR_ID_ALIGN);
    do_reset();
    jam = 1'b0;
    run(1'b0, 1'b1, n);
    check("align_reach", win(n, 28, 50), 16'h0001);
    jam = 1'b1;
    run(1'b0, 1'b0, n);
    check("align_leave", win(n, 190, 212), 16'h0001);
    latched(ERR_ID_ALIGN);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole run is about 4000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    final_report();
  end

  initial begin
    push_travel();
    push_away(16'h000a, ERR_ID_NONE);
    push_away(16'h03e8, ERR_ID_PUSH);
    push_leave_faults();
    push_arrive_faults();
    align_faults();
    final_report();
  end
endmodule // booklet_motor_home_supervisor_tb
